/* File: hw/ucc_pkg.sv */
package ucc_pkg;

  // Register offsets on the 3-bit register port.
  localparam logic [2:0] UCC_OFS_INTERRUPT_CONTROL = 3'h2;
  localparam logic [2:0] UCC_OFS_LINE_CONTROL = 3'h3;
  localparam logic [2:0] UCC_OFS_FRAME_FORMAT = 3'h4;

  localparam logic [7:0] UCC_RST_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] UCC_RST_LINE_CONTROL = 8'h00;
  localparam logic [7:0] UCC_RST_FRAME_FORMAT = 8'h00;

  // interrupt_control fields.
  localparam int UCC_START_IE_BIT = 7;
  localparam int UCC_DRECV_IE_BIT = 6;
  localparam int UCC_RXC_LVL_LO = 4;
  localparam int UCC_TXC_LVL_LO = 2;
  localparam int UCC_DRE_LVL_LO = 0;

  // line_control fields.
  localparam int UCC_SHARED_BIT = 7;
  localparam int UCC_SFD_BIT = 6;
  localparam int UCC_RECEIVER_ENABLE_BIT = 4;
  localparam int UCC_TRANSMITTER_ENABLE_BIT = 3;
  localparam int UCC_DBL_BIT = 2;
  localparam int UCC_ADDRESS_FILTER_MODE_BIT = 1;
  localparam int UCC_NINTH_BIT = 0;
  localparam logic [7:0] UCC_LINE_WMASK = 8'hDF;

  // frame_format fields, standard and master SPI layouts.
  localparam int UCC_MODE_LO = 6;
  localparam int UCC_PAR_LO = 4;
  localparam int UCC_STOP2_BIT = 3;
  localparam int UCC_CHSZ_LO = 0;
  localparam int UCC_ORDER_BIT = 2;
  localparam int UCC_PHASE_BIT = 1;
  localparam logic [7:0] UCC_FMT_SPI_MASK = 8'hC6;

  localparam logic [1:0] UCC_MODE_ASYNC = 2'h0;
  localparam logic [1:0] UCC_MODE_SYNC = 2'h1;
  localparam logic [1:0] UCC_MODE_IR = 2'h2;
  localparam logic [1:0] UCC_MODE_MSPI = 2'h3;

  localparam logic [2:0] UCC_CHSZ_9BIT = 3'h7;
  localparam logic [3:0] UCC_MIN_BITS = 4'h5;
  localparam logic [3:0] UCC_RSVD_BITS = 4'h8;
  localparam logic [3:0] UCC_NINE_BITS = 4'h9;
  localparam logic [3:0] UCC_SPI_BITS = 4'h8;

  // Baud ticks per bit, and index of the last SPI clock half period of a byte.
  localparam logic [4:0] UCC_OS_NORMAL = 5'h10;
  localparam logic [4:0] UCC_OS_DOUBLE = 5'h08;
  localparam logic [4:0] UCC_SPI_LAST_HALF = 5'h0F;

  typedef enum logic [4:0] {
    UCC_IDLE = 5'h01,
    UCC_START = 5'h02,
    UCC_DATA = 5'h04,
    UCC_PAR = 5'h08,
    UCC_STOP = 5'h10
  } ucc_state_e;

  typedef struct packed {
    logic [7:0] int_ctrl;
    logic [7:0] line_ctrl;
    logic [7:0] frame_fmt;
    logic [7:0] rdata;
    logic [1:0] sy1;
    logic [1:0] sy2;
    logic line_prev;
    ucc_state_e tx_st;
    logic [4:0] tx_cnt;
    logic [3:0] tx_bits;
    logic [8:0] tx_sh;
    logic tx_par;
    logic [8:0] tx_buf;
    logic tx_empty;
    logic tx_owned;
    logic txd;
    logic txd_oe;
    logic xck;
    logic xck_oe;
    logic txc_flag;
    ucc_state_e rx_st;
    logic [4:0] rx_cnt;
    logic [3:0] rx_bits;
    logic [8:0] rx_sh;
    logic rx_par;
    logic rx_addr;
    logic parity_error_flag_pend;
    logic [8:0] rx_buf;
    logic rx_valid;
    logic frame_error_flag;
    logic parity_error_flag;
    logic ovf;
    logic stop_flag;
    logic start_flag;
    logic wake;
    logic rx_owned;
    logic rxc_out;
    logic drecv_out;
    logic [1:0] rx_irq;
    logic [1:0] tx_irq;
    logic [1:0] dre_irq;
  } ucc_regs_s;

  localparam ucc_regs_s UCC_REGS_RESET = '{
    tx_st: UCC_IDLE,
    rx_st: UCC_IDLE,
    int_ctrl: UCC_RST_INTERRUPT_CONTROL,
    line_ctrl: UCC_RST_LINE_CONTROL,
    frame_fmt: UCC_RST_FRAME_FORMAT,
    tx_empty: 1'b1,
    txd: 1'b1,
    line_prev: 1'b1,
    sy1: 2'h3,
    sy2: 2'h3,
    default: '0
  };

endpackage

/* File: hw/ucc_usart_ctrl.sv */
`timescale 1ns/1ps
module ucc_usart_ctrl
  import ucc_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic baud_tick_in,
  input wire logic deep_sleep_in,
  input wire logic var_length_in,
  input wire logic [3:0] pec_length_in,
  input wire logic tx_write_in,
  input wire logic [7:0] tx_data_in,
  input wire logic rx_read_in,
  input wire logic recv_done_clear_in,
  input wire logic xmit_done_clear_in,
  input wire logic recv_start_clear_in,
  output logic [8:0] rx_data_out,
  output logic xmit_buffer_empty_flag_out,
  output logic recv_done_flag_out,
  output logic data_recv_flag_out,
  output logic recv_start_flag_out,
  output logic xmit_done_flag_out,
  output logic parity_error_flag_out,
  output logic frame_error_flag_out,
  output logic overflow_flag_out,
  output logic [1:0] rx_irq_level_out,
  output logic [1:0] tx_irq_level_out,
  output logic [1:0] dre_irq_level_out,
  output logic wake_out,
  input wire logic rxd_pin_in,
  input wire logic txd_pin_in,
  output logic txd_out,
  output logic txd_oe_out,
  output logic rx_pin_owned_out,
  output logic transfer_clock_pin_out,
  output logic transfer_clock_oe_out
);

  function automatic logic [7:0] ucc_rev8(input logic [7:0] d);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7 - i];
    end
    return r;
  endfunction

  // Received bits enter at the top, so a short frame sits high in the shifter.
  function automatic logic [8:0] ucc_align(input logic [8:0] sh, input logic [3:0] n);
    logic [3:0] amt;
    amt = UCC_NINE_BITS - n;
    return sh >> amt;
  endfunction

  ucc_regs_s s;
  ucc_regs_s n;

  logic [1:0] mode;
  logic spi;
  logic clocked;
  logic par_on;
  logic par_odd;
  logic stop2;
  logic lsb_first;
  logic phase1;
  logic rx_en;
  logic tx_en;
  logic [3:0] nbits;
  logic [4:0] os;
  logic rx_line;

  assign mode = s.frame_fmt[UCC_MODE_LO +: 2];
  assign spi = (mode == UCC_MODE_MSPI);
  assign clocked = (mode == UCC_MODE_SYNC) || spi;
  assign par_on = !spi && s.frame_fmt[UCC_PAR_LO + 1];
  assign par_odd = s.frame_fmt[UCC_PAR_LO];
  assign stop2 = !spi && s.frame_fmt[UCC_STOP2_BIT];
  assign lsb_first = s.frame_fmt[UCC_ORDER_BIT];
  assign phase1 = s.frame_fmt[UCC_PHASE_BIT];
  assign rx_en = s.line_ctrl[UCC_RECEIVER_ENABLE_BIT];
  assign tx_en = s.line_ctrl[UCC_TRANSMITTER_ENABLE_BIT];
  assign os = (!clocked && s.line_ctrl[UCC_DBL_BIT]) ? UCC_OS_DOUBLE : UCC_OS_NORMAL;
  // receive from the transmit pin in shared mode
  assign rx_line = s.line_ctrl[UCC_SHARED_BIT] ? s.sy2[1] : s.sy2[0];

  always_comb begin
    if (spi) begin
      nbits = UCC_SPI_BITS;
    end else if (var_length_in) begin
      nbits = pec_length_in;
    end else if (s.frame_fmt[UCC_CHSZ_LO +: 3] == UCC_CHSZ_9BIT) begin
      nbits = UCC_NINE_BITS;
    end else if (s.frame_fmt[UCC_CHSZ_LO + 2]) begin
      nbits = UCC_RSVD_BITS;
    end else begin
      nbits = UCC_MIN_BITS + {1'b0, s.frame_fmt[UCC_CHSZ_LO +: 3]};
    end
  end

  always_comb begin
    logic lead;
    logic trail;
    logic tx_step;
    logic rx_samp;
    logic dlv;
    logic dlv_frame_error_flag;
    logic [8:0] dlv_data;
    logic [4:0] rx_target;
    logic rx_req;
    lead = baud_tick_in && !s.xck;
    trail = baud_tick_in && s.xck;
    tx_step = 1'b0;
    rx_samp = 1'b0;
    dlv = 1'b0;
    dlv_frame_error_flag = 1'b0;
    dlv_data = '0;
    rx_target = '0;
    rx_req = 1'b0;
    n = s;

    n.sy1 = {txd_pin_in, rxd_pin_in};
    n.sy2 = s.sy1;
    n.line_prev = rx_line;
    n.rdata = '0;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        UCC_OFS_INTERRUPT_CONTROL: n.rdata = s.int_ctrl;
        UCC_OFS_LINE_CONTROL: n.rdata = s.line_ctrl;
        UCC_OFS_FRAME_FORMAT: n.rdata = spi ? (s.frame_fmt & UCC_FMT_SPI_MASK) : s.frame_fmt;
        default: n.rdata = '0;
      endcase
    end
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        UCC_OFS_INTERRUPT_CONTROL: n.int_ctrl = reg_wdata_in;
        UCC_OFS_LINE_CONTROL: n.line_ctrl = reg_wdata_in & UCC_LINE_WMASK;
        UCC_OFS_FRAME_FORMAT: n.frame_fmt = reg_wdata_in;
        default: n.int_ctrl = s.int_ctrl;
      endcase
    end

    // ninth bit latched with the data; dropped under counter control
    if (tx_write_in && s.tx_empty) begin
      n.tx_buf = {s.line_ctrl[UCC_NINTH_BIT] && !var_length_in, tx_data_in};
      n.tx_empty = 1'b0;
    end

    // Transfer clock: free running in sync mode, per byte in SPI mode.
    if (clocked && baud_tick_in && (spi ? (s.tx_st == UCC_DATA) : (tx_en || rx_en))) begin
      n.xck = !s.xck;
    end else if (!clocked || (spi && s.tx_st != UCC_DATA) || !(tx_en || rx_en)) begin
      n.xck = 1'b0;
    end
    if (!clocked && s.tx_st != UCC_IDLE && baud_tick_in) begin
      n.tx_cnt = (s.tx_cnt == 5'(os - 5'h01)) ? '0 : 5'(s.tx_cnt + 5'h01);
      tx_step = (s.tx_cnt == 5'(os - 5'h01));
    end else if (clocked) begin
      tx_step = trail;
    end
    if (xmit_done_clear_in) begin
      n.txc_flag = 1'b0;
    end

    unique case (s.tx_st)
      UCC_IDLE: begin
        if (!s.tx_empty && s.tx_owned) begin
          // MSB-first is reversed once so the shifter always sends bit 0
          n.tx_sh = (spi && !lsb_first) ? {1'b0, ucc_rev8(s.tx_buf[7:0])} : s.tx_buf;
          n.tx_empty = 1'b1;
          n.tx_cnt = '0;
          n.tx_bits = nbits;
          n.tx_par = 1'b0;
          n.tx_st = spi ? UCC_DATA : UCC_START;
        end
      end
      UCC_START: begin
        if (tx_step) begin
          n.tx_st = UCC_DATA;
        end
      end
      UCC_DATA: begin
        if (spi) begin
          if (baud_tick_in) begin
            n.tx_cnt = 5'(s.tx_cnt + 5'h01);
            // phase selects shift and sample edges
            if (phase1 ? (lead && s.tx_cnt != '0) : (trail && s.tx_cnt != UCC_SPI_LAST_HALF)) begin
              n.tx_sh = s.tx_sh >> 1;
            end
            if ((phase1 ? trail : lead) && rx_en) begin
              n.rx_sh = {s.sy2[0], s.rx_sh[8:1]};
            end
            if (s.tx_cnt == UCC_SPI_LAST_HALF) begin
              n.tx_st = UCC_IDLE;
              n.txc_flag = n.tx_empty;
              dlv = rx_en;
              dlv_data = ucc_align(n.rx_sh, UCC_SPI_BITS);
              dlv_data = lsb_first ? dlv_data : {1'b0, ucc_rev8(dlv_data[7:0])};
            end
          end
        end else if (tx_step) begin
          n.tx_par = s.tx_par ^ s.tx_sh[0];
          n.tx_sh = s.tx_sh >> 1;
          n.tx_bits = 4'(s.tx_bits - 4'h1);
          if (s.tx_bits == 4'h1) begin
            n.tx_bits = stop2 ? 4'h2 : 4'h1;
            n.tx_st = par_on ? UCC_PAR : UCC_STOP;
          end
        end
      end
      UCC_PAR: begin
        if (tx_step) begin
          n.tx_st = UCC_STOP;
        end
      end
      UCC_STOP: begin
        if (tx_step) begin
          n.tx_bits = 4'(s.tx_bits - 4'h1);
          if (s.tx_bits == 4'h1) begin
            n.tx_st = UCC_IDLE;
            n.txc_flag = n.tx_empty;
          end
        end
      end
      default: n.tx_st = UCC_IDLE;
    endcase

    // pin kept until shifter and buffer drain
    n.tx_owned = tx_en ? 1'b1 : ((s.tx_st != UCC_IDLE || !s.tx_empty) ? s.tx_owned : 1'b0);
    unique case (n.tx_st)
      UCC_START: n.txd = 1'b0;
      UCC_DATA: n.txd = n.tx_sh[0];
      UCC_PAR: n.txd = n.tx_par ^ par_odd;
      default: n.txd = 1'b1;
    endcase
    // shared pin is only driven while a frame is on the wire
    n.txd_oe = s.line_ctrl[UCC_SHARED_BIT] ? (n.tx_st != UCC_IDLE) : n.tx_owned;
    n.xck_oe = clocked && (tx_en || rx_en);

    // Receiver for all modes except SPI, which is clocked by the transmitter.
    rx_target = (s.rx_st == UCC_START) ? 5'((os >> 1) - 5'h01) : 5'(os - 5'h01);
    if (clocked) begin
      rx_samp = lead;
    end else if (s.rx_st != UCC_IDLE && baud_tick_in) begin
      rx_samp = (s.rx_cnt == rx_target);
      n.rx_cnt = rx_samp ? '0 : 5'(s.rx_cnt + 5'h01);
    end
    if (!spi && rx_en) begin
      unique case (s.rx_st)
        UCC_IDLE: begin
          if (clocked ? (lead && !rx_line) : (s.line_prev && !rx_line)) begin
            n.rx_cnt = '0;
            n.rx_bits = nbits;
            n.rx_par = 1'b0;
            n.rx_st = clocked ? UCC_DATA : UCC_START;
          end
        end
        UCC_START: begin
          if (rx_samp) begin
            n.rx_bits = nbits;
            n.rx_par = 1'b0;
            n.rx_st = rx_line ? UCC_IDLE : UCC_DATA;
          end
        end
        UCC_DATA: begin
          if (rx_samp) begin
            n.rx_sh = {rx_line, s.rx_sh[8:1]};
            n.rx_par = s.rx_par ^ rx_line;
            n.rx_bits = 4'(s.rx_bits - 4'h1);
            n.parity_error_flag_pend = 1'b0;
            if (s.rx_bits == 4'h1) begin
              n.rx_addr = rx_line;
              n.rx_st = par_on ? UCC_PAR : UCC_STOP;
            end
          end
        end
        UCC_PAR: begin
          if (rx_samp) begin
            n.parity_error_flag_pend = s.rx_par ^ rx_line ^ par_odd;
            n.rx_st = UCC_STOP;
          end
        end
        UCC_STOP: begin
          if (rx_samp) begin
            // only the first stop bit is checked
            n.rx_st = UCC_IDLE;
            dlv = 1'b1;
            dlv_frame_error_flag = !rx_line;
            dlv_data = ucc_align(s.rx_sh, nbits);
          end
        end
        default: n.rx_st = UCC_IDLE;
      endcase
    end

    if (recv_done_clear_in) begin
      n.stop_flag = 1'b0;
    end
    if (rx_read_in) begin
      n.rx_valid = 1'b0;
      n.frame_error_flag = 1'b0;
      n.parity_error_flag = 1'b0;
      n.ovf = 1'b0;
    end
    // unaddressed frames are dropped without a trace
    if (dlv && !(s.line_ctrl[UCC_ADDRESS_FILTER_MODE_BIT] && !spi && !n.rx_addr)) begin
      n.stop_flag = 1'b1;
      if (n.rx_valid) begin
        n.ovf = 1'b1;
      end else begin
        n.rx_buf = dlv_data;
        n.rx_valid = 1'b1;
        n.frame_error_flag = dlv_frame_error_flag;
        n.parity_error_flag = par_on && n.parity_error_flag_pend;
      end
    end
    // receiver disable flushes data and error flags
    if (!rx_en) begin
      n.rx_st = UCC_IDLE;
      n.rx_valid = 1'b0;
      n.frame_error_flag = 1'b0;
      n.parity_error_flag = 1'b0;
      n.ovf = 1'b0;
      n.stop_flag = 1'b0;
    end
    n.rx_owned = rx_en;

    // start condition seen only in deep sleep
    if (recv_start_clear_in) begin
      n.start_flag = 1'b0;
    end
    // wake request from the start detector
    n.wake = s.line_ctrl[UCC_SFD_BIT] && deep_sleep_in && !spi && s.line_prev && !rx_line;
    if (n.wake) begin
      n.start_flag = 1'b1;
    end
    if (!s.line_ctrl[UCC_SFD_BIT]) begin
      n.start_flag = 1'b0;
    end

    // data reception flag tracks the buffer in variable length only
    n.drecv_out = var_length_in && n.rx_valid;
    n.rxc_out = var_length_in ? n.stop_flag : n.rx_valid;
    // start flag shares the receive vector and level
    rx_req = n.rxc_out || (n.int_ctrl[UCC_START_IE_BIT] && n.start_flag);
    // data reception shares the receive vector and level
    rx_req = rx_req || (n.int_ctrl[UCC_DRECV_IE_BIT] && n.drecv_out);
    n.rx_irq = rx_req ? n.int_ctrl[UCC_RXC_LVL_LO +: 2] : 2'h0;
    n.tx_irq = n.txc_flag ? n.int_ctrl[UCC_TXC_LVL_LO +: 2] : 2'h0;
    n.dre_irq = n.tx_empty ? n.int_ctrl[UCC_DRE_LVL_LO +: 2] : 2'h0;
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s <= UCC_REGS_RESET;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata_out = s.rdata;
  assign rx_data_out = s.rx_buf;
  assign xmit_buffer_empty_flag_out = s.tx_empty;
  assign recv_done_flag_out = s.rxc_out;
  assign data_recv_flag_out = s.drecv_out;
  assign recv_start_flag_out = s.start_flag;
  assign xmit_done_flag_out = s.txc_flag;
  assign parity_error_flag_out = s.parity_error_flag;
  assign frame_error_flag_out = s.frame_error_flag;
  assign overflow_flag_out = s.ovf;
  assign rx_irq_level_out = s.rx_irq;
  assign tx_irq_level_out = s.tx_irq;
  assign dre_irq_level_out = s.dre_irq;
  assign wake_out = s.wake;
  assign txd_out = s.txd;
  assign txd_oe_out = s.txd_oe;
  assign rx_pin_owned_out = s.rx_owned;
  assign transfer_clock_pin_out = s.xck;
  assign transfer_clock_oe_out = s.xck_oe;

endmodule

/* File: tb/ucc_usart_properties.sv */
`timescale 1ns/1ps
module ucc_usart_chk
  import ucc_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [2:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic deep_sleep_in,
  input wire logic var_length_in,
  input wire logic xmit_buffer_empty_flag_out,
  input wire logic recv_done_flag_out,
  input wire logic data_recv_flag_out,
  input wire logic recv_start_flag_out,
  input wire logic xmit_done_flag_out,
  input wire logic parity_error_flag_out,
  input wire logic frame_error_flag_out,
  input wire logic overflow_flag_out,
  input wire logic [1:0] rx_irq_level_out,
  input wire logic [1:0] tx_irq_level_out,
  input wire logic [1:0] dre_irq_level_out,
  input wire logic wake_out,
  input wire logic txd_out,
  input wire logic txd_oe_out,
  input wire logic rx_pin_owned_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);
  logic rx_any;
  assign rx_any = recv_done_flag_out | recv_start_flag_out | data_recv_flag_out;
  sequence s_rd_line;
    reg_rd_in && reg_addr_in == UCC_OFS_LINE_CONTROL;
  endsequence
  sequence s_rd_fmt_spi;
    reg_rd_in && reg_addr_in == UCC_OFS_FRAME_FORMAT ##1 reg_rdata_out[7:6] == UCC_MODE_MSPI;
  endsequence
  property p_rsvd_zero;
    s_rd_line |=> reg_rdata_out[5] == 1'b0;
  endproperty
  property p_spi_layout;
    s_rd_fmt_spi |-> (reg_rdata_out & ~UCC_FMT_SPI_MASK) == 8'h00;
  endproperty
  property p_rx_irq_cause;
    rx_irq_level_out != 2'h0 |-> rx_any || $past(rx_any);
  endproperty
  property p_tx_irq_cause;
    tx_irq_level_out != 2'h0 |-> xmit_done_flag_out || $past(xmit_done_flag_out);
  endproperty
  property p_dre_irq_cause;
    dre_irq_level_out != 2'h0 |-> xmit_buffer_empty_flag_out || $past(xmit_buffer_empty_flag_out);
  endproperty
  property p_wake_sleep;
    wake_out |-> deep_sleep_in && $past(deep_sleep_in) ##1 !wake_out;
  endproperty
  property p_wake_flag;
    $rose(wake_out) |-> ##[0:2] recv_start_flag_out;
  endproperty
  property p_tx_release;
    $fell(txd_oe_out) |-> xmit_buffer_empty_flag_out && $past(txd_out);
  endproperty
  property p_rx_flush;
    $fell(rx_pin_owned_out) |-> ##[0:2] !(frame_error_flag_out || parity_error_flag_out
      || overflow_flag_out || recv_done_flag_out);
  endproperty
  property p_drecv_var;
    data_recv_flag_out |-> var_length_in || $past(var_length_in);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read high");
  a_spi_layout: assert property (p_spi_layout) else $error("spi layout bits set");
  a_rx_irq_cause: assert property (p_rx_irq_cause) else $error("rx request no flag");
  a_tx_irq_cause: assert property (p_tx_irq_cause) else $error("tx request no flag");
  a_dre_irq_cause: assert property (p_dre_irq_cause) else $error("dre request no flag");
  a_wake_sleep: assert property (p_wake_sleep) else $error("wake outside sleep");
  a_wake_flag: assert property (p_wake_flag) else $error("wake without start flag");
  a_tx_release: assert property (p_tx_release) else $error("tx pin released early");
  a_rx_flush: assert property (p_rx_flush) else $error("rx flags kept after off");
  a_drecv_var: assert property (p_drecv_var) else $error("data flag in std mode");
endmodule
bind ucc_usart_ctrl ucc_usart_chk ucc_usart_chk_i (
  .clock_in(clock_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .deep_sleep_in(deep_sleep_in),
  .var_length_in(var_length_in), .xmit_buffer_empty_flag_out(xmit_buffer_empty_flag_out),
  .recv_done_flag_out(recv_done_flag_out), .data_recv_flag_out(data_recv_flag_out),
  .recv_start_flag_out(recv_start_flag_out), .xmit_done_flag_out(xmit_done_flag_out),
  .parity_error_flag_out(parity_error_flag_out), .frame_error_flag_out(frame_error_flag_out),
  .overflow_flag_out(overflow_flag_out), .rx_irq_level_out(rx_irq_level_out),
  .tx_irq_level_out(tx_irq_level_out), .dre_irq_level_out(dre_irq_level_out),
  .wake_out(wake_out), .txd_out(txd_out), .txd_oe_out(txd_oe_out),
  .rx_pin_owned_out(rx_pin_owned_out));

/* File: tb/ucc_peer_model.sv */
`timescale 1ns/1ps
module ucc_peer_model (
  input wire logic clock_in,
  output logic rxd_out
);
  initial rxd_out = 1'b1;
  // The line idles high between frames, as a pulled-up line would.
  task automatic send(input logic [11:0] bits, input int n, input int cyc);
    @(posedge clock_in);
    for (int i = 0; i < n; i++) begin
      rxd_out <= bits[i];
      repeat (cyc) @(posedge clock_in);
    end
    rxd_out <= 1'b1;
  endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import ucc_pkg::*;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] txdat = 8'h00;
  logic wr = 1'b0, rd = 1'b0, slp = 1'b0, varlen = 1'b0, txw = 1'b0, rxr = 1'b0;
  logic tclr = 1'b0, sclr = 1'b0;
  logic [7:0] rdata;
  logic [8:0] rxdat;
  logic dre, rxc, drf, rsf, txc, parity_error_flag, frame_error_flag, ovf, wake, txd, txoe, rown, xck, rxd, xoe;
  logic [1:0] rxl, txl, drl;
  int n_fail = 0;
  int compares = 0;
  int n_wake = 0;
  always #2.5 clock_in = ~clock_in;
  always @(negedge clock_in) n_wake += int'(wake);
  ucc_peer_model ucc_peer_model_i (.clock_in(clock_in), .rxd_out(rxd));
  ucc_usart_ctrl ucc_usart_ctrl_i (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .baud_tick_in(1'b1),
    .deep_sleep_in(slp), .var_length_in(varlen), .pec_length_in(4'h8), .tx_write_in(txw),
    .tx_data_in(txdat), .rx_read_in(rxr), .recv_done_clear_in(1'b0),
    .xmit_done_clear_in(tclr), .recv_start_clear_in(sclr), .rx_data_out(rxdat),
    .xmit_buffer_empty_flag_out(dre), .recv_done_flag_out(rxc), .data_recv_flag_out(drf),
    .recv_start_flag_out(rsf), .xmit_done_flag_out(txc), .parity_error_flag_out(parity_error_flag),
    .frame_error_flag_out(frame_error_flag), .overflow_flag_out(ovf), .rx_irq_level_out(rxl),
    .tx_irq_level_out(txl), .dre_irq_level_out(drl), .wake_out(wake), .rxd_pin_in(rxd),
    .txd_pin_in(txd), .txd_out(txd), .txd_oe_out(txoe), .rx_pin_owned_out(rown),
    .transfer_clock_pin_out(xck), .transfer_clock_oe_out(xoe));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock_in);
    rd <= 1'b0;
    @(negedge clock_in);
    chk(9'(rdata), 9'(e));
  endtask
  task automatic t_regs();
    rchk(UCC_OFS_INTERRUPT_CONTROL, UCC_RST_INTERRUPT_CONTROL);
    rchk(UCC_OFS_LINE_CONTROL, UCC_RST_LINE_CONTROL);
    rchk(UCC_OFS_FRAME_FORMAT, UCC_RST_FRAME_FORMAT);
    chk(9'(dre), 9'h1);
    wreg(3'h7, 8'hFF);
    rchk(3'h7, 8'h00);
    wreg(UCC_OFS_INTERRUPT_CONTROL, 8'hFF);
    rchk(UCC_OFS_INTERRUPT_CONTROL, 8'hFF);
    wreg(UCC_OFS_LINE_CONTROL, 8'hFF);
    rchk(UCC_OFS_LINE_CONTROL, 8'hDF);
    for (int m = 0; m < 4; m++) begin
      wreg(UCC_OFS_FRAME_FORMAT, {2'(m), 6'h3F});
      rchk(UCC_OFS_FRAME_FORMAT, m == 3 ? 8'hC6 : {2'(m), 6'h3F});
    end
    for (int a = 2; a < 5; a++) wreg(3'(a), 8'h00);
    $display("register test done");
  endtask
  task automatic t_tx(input logic [7:0] fmt, input logic [7:0] line, input logic [8:0] d,
      input int nb, input int pm, input int ns, input int os);
    logic p;
    int i;
    p = 1'b0;
    wreg(UCC_OFS_INTERRUPT_CONTROL, 8'h09);
    wreg(UCC_OFS_FRAME_FORMAT, fmt);
    wreg(UCC_OFS_LINE_CONTROL, line);
    @(posedge clock_in);
    txw <= 1'b1;
    txdat <= d[7:0];
    @(posedge clock_in);
    txw <= 1'b0;
    // Disable is requested while the character is still pending.
    wreg(UCC_OFS_LINE_CONTROL, line & 8'hF7);
    for (i = 0; i < 40 && txd !== 1'b0; i++) @(negedge clock_in);
    repeat (os / 2) @(negedge clock_in);
    chk(9'(txd), 9'h0);
    for (i = 0; i < nb; i++) begin
      repeat (os) @(negedge clock_in);
      chk(9'(txd), 9'(d[i]));
      p ^= d[i];
    end
    if (pm != 0) begin
      repeat (os) @(negedge clock_in);
      chk(9'(txd), 9'(p ^ (pm == 3)));
    end
    repeat (os) @(negedge clock_in);
    chk(9'({txd, txoe}), 9'h3);
    repeat (os) @(negedge clock_in);
    chk(9'(txc), 9'(ns == 1));
    repeat (os + 4) @(negedge clock_in);
    chk({txc, txl, drl, txoe}, 9'h032);
    @(posedge clock_in);
    tclr <= 1'b1;
    @(posedge clock_in);
    tclr <= 1'b0;
    repeat (3) @(negedge clock_in);
    chk(9'(txl), 9'h0);
    wreg(UCC_OFS_INTERRUPT_CONTROL, 8'h00);
    $display("transmit test done");
  endtask
  task automatic t_rx(input logic [7:0] fmt, input logic [7:0] line, input logic [11:0] f,
      input int n, input logic [8:0] e, input logic ok, input logic pe);
    wreg(UCC_OFS_INTERRUPT_CONTROL, 8'h10);
    wreg(UCC_OFS_FRAME_FORMAT, fmt);
    wreg(UCC_OFS_LINE_CONTROL, line);
    repeat (2) @(negedge clock_in);
    chk(9'(rown), 9'h1);
    ucc_peer_model_i.send(f, n, 16);
    repeat (20) @(negedge clock_in);
    chk(9'(rxc), 9'(ok));
    if (ok) begin
      chk(rxdat, e);
      chk({4'h0, rxl, parity_error_flag, drf, frame_error_flag}, {6'h01, pe, 2'h0});
    end
    wreg(UCC_OFS_LINE_CONTROL, 8'h00);
    repeat (3) @(negedge clock_in);
    chk(9'({rxc, parity_error_flag, frame_error_flag, ovf, rown}), 9'h0);
    wreg(UCC_OFS_INTERRUPT_CONTROL, 8'h00);
    $display("receive test done");
  endtask
  task automatic t_sleep(input logic s);
    int w0;
    wreg(UCC_OFS_INTERRUPT_CONTROL, 8'h90);
    wreg(UCC_OFS_LINE_CONTROL, 8'h40);
    slp <= s;
    repeat (4) @(posedge clock_in);
    w0 = n_wake;
    ucc_peer_model_i.send(12'h3FE, 10, 16);
    repeat (10) @(negedge clock_in);
    chk(9'(n_wake - w0), 9'(s));
    chk({6'h0, rsf, rxl}, {6'h0, s, 1'b0, s});
    @(posedge clock_in);
    sclr <= 1'b1;
    @(posedge clock_in);
    sclr <= 1'b0;
    slp <= 1'b0;
    repeat (3) @(negedge clock_in);
    chk(9'(rsf), 9'h0);
    wreg(UCC_OFS_LINE_CONTROL, 8'h00);
    wreg(UCC_OFS_INTERRUPT_CONTROL, 8'h00);
    $display("start detect test done");
  endtask
  task automatic t_varlen();
    varlen <= 1'b1;
    wreg(UCC_OFS_FRAME_FORMAT, 8'h07);
    wreg(UCC_OFS_INTERRUPT_CONTROL, 8'h50);
    wreg(UCC_OFS_LINE_CONTROL, 8'h10);
    ucc_peer_model_i.send(12'h278, 10, 16);
    repeat (20) @(negedge clock_in);
    chk({6'h0, drf, rxl}, 9'h5);
    @(posedge clock_in);
    rxr <= 1'b1;
    @(posedge clock_in);
    rxr <= 1'b0;
    repeat (3) @(negedge clock_in);
    chk(9'(drf), 9'h0);
    wreg(UCC_OFS_LINE_CONTROL, 8'h00);
    varlen <= 1'b0;
    wreg(UCC_OFS_FRAME_FORMAT, 8'h00);
    wreg(UCC_OFS_INTERRUPT_CONTROL, 8'h00);
    $display("variable length test done");
  endtask
  task automatic t_spi(input logic o, input logic ph, input logic [7:0] d);
    logic [7:0] got, e;
    logic prev, pt;
    int k;
    k = 0;
    prev = 1'b0;
    for (int i = 0; i < 8; i++) e[7 - i] = o ? d[i] : d[7 - i];
    wreg(UCC_OFS_FRAME_FORMAT, {UCC_MODE_MSPI, 3'h0, o, ph, 1'b0});
    wreg(UCC_OFS_LINE_CONTROL, 8'h08);
    @(posedge clock_in);
    txw <= 1'b1;
    txdat <= d;
    @(posedge clock_in);
    txw <= 1'b0;
    // Data is taken at the sampling edge picked by the phase bit.
    for (int i = 0; i < 300 && k < 8; i++) begin
      @(negedge clock_in);
      if (xck !== prev && xck === !ph) begin
        got = {got[6:0], pt};
        k++;
      end
      prev = xck;
      pt = txd;
    end
    chk(9'(got), 9'(e));
    chk(9'(xoe), 9'h1);
    repeat (40) @(negedge clock_in);
    wreg(UCC_OFS_LINE_CONTROL, 8'h00);
    wreg(UCC_OFS_FRAME_FORMAT, 8'h00);
    $display("spi test done");
  endtask
  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clock_in);
    reset_n_in <= 1'b1;
    @(posedge clock_in);
    t_regs();
    t_tx(8'h03, 8'h08, 9'h0A5, 8, 0, 1, 16);
    t_tx(8'h2A, 8'h0C, 9'h05B, 7, 2, 2, 8);
    t_tx(8'h37, 8'h09, 9'h1C3, 9, 3, 1, 16);
    t_tx(8'h00, 8'h08, 9'h015, 5, 0, 1, 16);
    t_rx(8'h03, 8'h10, 12'h278, 10, 9'h03C, 1'b1, 1'b0);
    t_rx(8'h23, 8'h10, 12'h478, 11, 9'h03C, 1'b1, 1'b0);
    t_rx(8'h33, 8'h10, 12'h478, 11, 9'h03C, 1'b1, 1'b1);
    t_rx(8'h03, 8'h12, 12'h278, 10, 9'h03C, 1'b0, 1'b0);
    t_rx(8'h03, 8'h12, 12'h378, 10, 9'h0BC, 1'b1, 1'b0);
    t_sleep(1'b1);
    t_sleep(1'b0);
    t_varlen();
    for (int c = 0; c < 4; c++) t_spi(c[1], c[0], 8'h4D);
    print_verdict();
  end
endmodule
